/* hdl/dtct_top.sv */
// Dual timebase timer with input capture behind an APB slave
// ------------------------------------------------------------
// Top module
// ------------------------------------------------------------
//
// Chosen here: the APB slave port and the address map.
module dtct_top #(
	parameter int PRESCALE = dtct_pkg::OSC_PER_TICK
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dtct_pkg::ADDR_W-1:0] paddr,
	input wire logic [dtct_pkg::DATA_W-1:0] pwdata,
	output logic [dtct_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic halt_mode,
	output logic timebase1_irq,
	output logic timebase2_irq,
	output logic capture_irq
);

	localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (PRESCALE < 2) begin : g_bad_prescale
		$error("PRESCALE must be at least 2");
	end

	// Index decode shared by setup and access phases
	function automatic logic [7:0] dtct_index(input logic [dtct_pkg::ADDR_W-1:0] a);
		dtct_index = a[dtct_pkg::ADDR_SHIFT +: 8];
	endfunction : dtct_index

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [PW-1:0] pre_q;
	logic [7:0] cnt1_q;
	logic half_q;
	logic [7:0] cnt2_q;
	logic [7:0] reload_q;
	logic [7:0] capture_q;
	logic tb1_flag_q, tb2_flag_q, cap_flag_q;
	logic tb1_en_q, tb2_en_q, cap_en_q, dbl_sel_q;
	logic [2:0] pin_q;
	logic [dtct_pkg::DATA_W-1:0] prdata_q;
	logic pready_q, pslverr_q;
	logic tb1_irq_q, tb2_irq_q, cap_irq_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire [7:0] idx_w = dtct_index(paddr);
	wire low_ok_w = (paddr[dtct_pkg::ADDR_SHIFT-1:0] == '0) && (paddr[dtct_pkg::ADDR_W-1:dtct_pkg::ADDR_SHIFT+8] == '0);
	wire hit_csr2_w = low_ok_w && (idx_w == dtct_pkg::IDX_TIMEBASE2_CTRL_STATUS);
	wire hit_rel_w = low_ok_w && (idx_w == dtct_pkg::IDX_COUNTER2_RELOAD_REG);
	wire hit_cnt2_w = low_ok_w && (idx_w == dtct_pkg::IDX_COUNTER2_VALUE_REG);
	wire hit_csr1_w = low_ok_w && (idx_w == dtct_pkg::IDX_TIMEBASE1_CTRL_STATUS);
	wire hit_cap_w = low_ok_w && (idx_w == dtct_pkg::IDX_CAPTURE_VALUE_REG);
	wire mapped_w = hit_csr2_w | hit_rel_w | hit_cnt2_w | hit_csr1_w | hit_cap_w;
	wire setup_w = psel && !penable;
	wire access_w = psel && penable && pready_q;
	wire wr_w = access_w && pwrite && mapped_w;
	wire rd_w = access_w && !pwrite && mapped_w;

	// Read view of each register; reserved bits read as zero
	wire [7:0] csr1_view_w = {cap_en_q, cap_flag_q, dbl_sel_q, tb1_en_q, tb1_flag_q, 3'h0};
	wire [7:0] csr2_view_w = {6'h00, tb2_en_q, tb2_flag_q};
	wire [7:0] rd_byte_w = hit_csr1_w ? csr1_view_w :
		hit_csr2_w ? csr2_view_w :
		hit_rel_w ? reload_q :
		hit_cnt2_w ? cnt2_q :
		hit_cap_w ? capture_q : dtct_pkg::RST_BYTE;

	// ------------------------------------------------------------
	// Timebase events
	// ------------------------------------------------------------
	// Halt freezes the prescaler too, so the phase resumes cleanly
	wire tick_w = (pre_q == PRE_LAST) && !halt_mode;
	wire wrap1_w = tick_w && (cnt1_q == dtct_pkg::CNT1_TOP);
	// Double mode only reports every second wrap
	wire ovf1_w = wrap1_w && (!dbl_sel_q || half_q);
	wire ovf2_w = tick_w && (cnt2_q == dtct_pkg::CNT2_TOP);

	// ------------------------------------------------------------
	// Capture edge; only the second and third stages feed logic
	// ------------------------------------------------------------
	wire edge_w = pin_q[2] ^ pin_q[1];
	wire cap_w = edge_w && !cap_flag_q;

	// Timebase flags clear only if the read reported them set, so a set in between is kept; the capture flag clears on any capture value read
	wire clr_tb1_w = rd_w && hit_csr1_w && prdata_q[dtct_pkg::BIT_TIMEBASE1_FLAG];
	wire clr_tb2_w = rd_w && hit_csr2_w && prdata_q[dtct_pkg::BIT_TIMEBASE2_FLAG];
	wire clr_cap_w = rd_w && hit_cap_w && cap_flag_q;

	// ------------------------------------------------------------
	// Prescaler and counter one
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= '0;
			cnt1_q <= dtct_pkg::CNT_ZERO;
			half_q <= 1'b0;
		end else begin
			if (!halt_mode) begin
				pre_q <= tick_w ? '0 : pre_q + PW'(1);
			end
			if (tick_w) begin
				cnt1_q <= wrap1_w ? dtct_pkg::CNT_ZERO : cnt1_q + 8'h01;
			end
			if (wrap1_w) begin
				half_q <= !half_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Counter two with reload
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt2_q <= dtct_pkg::RST_BYTE;
			reload_q <= dtct_pkg::RST_BYTE;
		end else begin
			if (tick_w) begin
				cnt2_q <= ovf2_w ? reload_q : cnt2_q + 8'h01;
			end
			if (wr_w && hit_rel_w) begin
				reload_q <= pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Control bits written by software
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cap_en_q <= 1'b0;
			dbl_sel_q <= 1'b0;
			tb1_en_q <= 1'b0;
			tb2_en_q <= 1'b0;
		end else begin
			if (wr_w && hit_csr1_w) begin
				cap_en_q <= pwdata[dtct_pkg::BIT_CAPTURE_IRQ_EN];
				dbl_sel_q <= pwdata[dtct_pkg::BIT_PERIOD_DOUBLE_SELECT];
				tb1_en_q <= pwdata[dtct_pkg::BIT_TIMEBASE1_IRQ_EN];
			end
			if (wr_w && hit_csr2_w) begin
				tb2_en_q <= pwdata[dtct_pkg::BIT_TIMEBASE2_IRQ_EN];
			end
		end
	end

	// ------------------------------------------------------------
	// Sticky flags: hardware set wins over a read clear; writes ignored
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tb1_flag_q <= 1'b0;
			tb2_flag_q <= 1'b0;
			cap_flag_q <= 1'b0;
		end else begin
			tb1_flag_q <= ovf1_w | (tb1_flag_q & !clr_tb1_w);
			tb2_flag_q <= ovf2_w | (tb2_flag_q & !clr_tb2_w);
			cap_flag_q <= cap_w | (cap_flag_q & !clr_cap_w);
		end
	end

	// ------------------------------------------------------------
	// Capture pin synchroniser and capture register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q <= 3'h0;
			capture_q <= dtct_pkg::RST_BYTE;
		end else begin
			pin_q <= {pin_q[1:0], capture_input_pin};
			if (cap_w) begin
				capture_q <= cnt1_q;
			end
		end
	end

	// ------------------------------------------------------------
	// APB answer: data sampled in setup, ready in the access cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup_w;
			if (setup_w) begin
				prdata_q <= {24'h000000, rd_byte_w};
				pslverr_q <= !mapped_w;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt levels, registered
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tb1_irq_q <= 1'b0;
			tb2_irq_q <= 1'b0;
			cap_irq_q <= 1'b0;
		end else begin
			tb1_irq_q <= tb1_flag_q & tb1_en_q;
			tb2_irq_q <= tb2_flag_q & tb2_en_q;
			cap_irq_q <= cap_flag_q & cap_en_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign timebase1_irq = tb1_irq_q;
	assign timebase2_irq = tb2_irq_q;
	assign capture_irq = cap_irq_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// Independent count of running cycles between ticks; works for any PRESCALE
	logic [PW-1:0] gap_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_q <= '0;
		end else if (tick_w) begin
			gap_q <= '0;
		end else if (!halt_mode) begin
			gap_q <= gap_q + PW'(1);
		end
	end

	property p_tick_space;
		tick_w |-> (gap_q == PRE_LAST);
	endproperty
	a_tick_space: assert property (p_tick_space) else $error("prescaler tick too soon");

	property p_cnt1_wrap;
		wrap1_w |=> (cnt1_q == dtct_pkg::CNT_ZERO);
	endproperty
	a_cnt1_wrap: assert property (p_cnt1_wrap) else $error("counter one did not wrap to zero");

	property p_dbl_skip;
		(wrap1_w && dbl_sel_q && !half_q) |-> !ovf1_w ##1 half_q;
	endproperty
	a_dbl_skip: assert property (p_dbl_skip) else $error("double period not applied");

	property p_tb1_set;
		ovf1_w |=> tb1_flag_q ##1 (tb1_irq_q == $past(tb1_en_q));
	endproperty
	a_tb1_set: assert property (p_tb1_set) else $error("flag one or its irq wrong");

	property p_tb1_clear;
		(rd_w && hit_csr1_w && prdata_q[dtct_pkg::BIT_TIMEBASE1_FLAG] && !ovf1_w) |=> !tb1_flag_q;
	endproperty
	a_tb1_clear: assert property (p_tb1_clear) else $error("flag one not cleared by read");

	property p_cap_load;
		cap_w |=> (capture_q == $past(cnt1_q)) && cap_flag_q;
	endproperty
	a_cap_load: assert property (p_cap_load) else $error("capture not loaded with flag");

	property p_cap_hold;
		(cap_flag_q && !clr_cap_w) |=> $stable(capture_q) && cap_flag_q;
	endproperty
	a_cap_hold: assert property (p_cap_hold) else $error("capture changed while flag set");

	property p_cap_irq;
		(cap_flag_q && cap_en_q) |=> capture_irq;
	endproperty
	a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

	property p_cnt2_reload;
		ovf2_w |=> (cnt2_q == $past(reload_q)) ##0 tb2_flag_q;
	endproperty
	a_cnt2_reload: assert property (p_cnt2_reload) else $error("counter two reload wrong");

	property p_halt;
		halt_mode |=> $stable(cnt1_q) && $stable(cnt2_q);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved during halt");

	property p_tb2_clear;
		(rd_w && hit_csr2_w && prdata_q[dtct_pkg::BIT_TIMEBASE2_FLAG] && !ovf2_w) |=> !tb2_flag_q;
	endproperty
	a_tb2_clear: assert property (p_tb2_clear) else $error("flag two not cleared by read");

	property p_cnt2_step;
		(tick_w && !ovf2_w) |=> (cnt2_q == $past(cnt2_q) + 8'h01);
	endproperty
	a_cnt2_step: assert property (p_cnt2_step) else $error("counter two jumped before overflow");

	property p_cap_ro;
		(wr_w && hit_cap_w && !cap_w) |=> $stable(capture_q);
	endproperty
	a_cap_ro: assert property (p_cap_ro) else $error("capture register took a write");

	c_ovf1: cover property (ovf1_w ##1 tb1_flag_q);
	c_capture: cover property (cap_w ##[1:20] clr_cap_w);
	c_reload: cover property (ovf2_w && reload_q != dtct_pkg::RST_BYTE);
	c_ignored_edge: cover property (edge_w && cap_flag_q);

endmodule : dtct_top

/* hdl/dtct_pkg.sv */
// Package: register map, field layout and timing constants of the dual timebase capture timer
package dtct_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_TIMEBASE2_CTRL_STATUS = 8'h08;
	localparam logic [7:0] IDX_COUNTER2_RELOAD_REG = 8'h09;
	localparam logic [7:0] IDX_COUNTER2_VALUE_REG = 8'h0A;
	localparam logic [7:0] IDX_TIMEBASE1_CTRL_STATUS = 8'h0B;
	localparam logic [7:0] IDX_CAPTURE_VALUE_REG = 8'h0C;
	localparam int ADDR_W = 12;
	localparam int ADDR_SHIFT = 2;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIT_CAPTURE_IRQ_EN = 7;
	localparam int BIT_CAPTURE_FLAG = 6;
	localparam int BIT_PERIOD_DOUBLE_SELECT = 5;
	localparam int BIT_TIMEBASE1_IRQ_EN = 4;
	localparam int BIT_TIMEBASE1_FLAG = 3;
	localparam int BIT_TIMEBASE2_IRQ_EN = 1;
	localparam int BIT_TIMEBASE2_FLAG = 0;

	// ------------------------------------------------------------
	// Reset values and counter limits
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CNT2_TOP = 8'hFF;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam int DATA_W = 32;

	// ------------------------------------------------------------
	// Timing: oscillator periods per prescaler tick and per timebase
	// ------------------------------------------------------------
	localparam int OSC_PER_TICK = 32;
	localparam int TB_PERIOD_OSC = 8000;
	localparam int CNT1_MODULUS = TB_PERIOD_OSC / OSC_PER_TICK;
	localparam logic [7:0] CNT1_TOP = 8'(CNT1_MODULUS - 1);

endpackage : dtct_pkg

/* test/dtct_pin_model.sv */
// Capture pin driver standing in for the external edge source
module dtct_pin_model (
	input wire logic clk,
	output logic capture_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Pin driver
	// ------------------------------------------------------------
	// Pin idles low after power-up
	initial capture_input_pin = 1'b0;

	// Flip the pin after an idle gap, right on the edge
	task flip(input int gap);
		repeat (gap) @(posedge clk);
		capture_input_pin <= ~capture_input_pin;
	endtask : flip
endmodule : dtct_pin_model

/* test/dtct_test.sv */
// Self-checking bench of the timer: APB traffic, timebases, capture, halt
module dtct_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int P = 2; // Short prescaler keeps the run brief
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic halt_mode = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin;
	logic [2:0] irqs;
	logic [31:0] rd;
	logic [31:0] v1;
	logic err;
	int errors = 0;
	int total_checks = 0;
	int seed = 73;
	int dv;
	int de;
	time t1;
	time t2;

	// Clock of 10 ns
	always #5 clk = ~clk;

	dtct_top #(.PRESCALE(P)) dtct_top_inst (
		.clk(clk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.capture_input_pin(pin),
		.halt_mode(halt_mode),
		.timebase1_irq(irqs[0]),
		.timebase2_irq(irqs[1]),
		.capture_irq(irqs[2])
	);

	dtct_pin_model dtct_pin_model_inst (
		.clk(clk),
		.capture_input_pin(pin)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Compare and count
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// One APB transfer; no latency assumed, the watchdog ends a hang
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read and compare
	task rdc(input logic [7:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0000_0000);
		chk(rd, e);
	endtask : rdc

	// Wait for an irq to rise; lag of a cleared level is skipped first
	task wup(input int k, output time t);
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		while (irqs[k] !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk({31'h0, irqs[k]}, 32'h1);
		t = $time;
	endtask : wup

	// Counts, then verdict; the only end of the run
	task final_report;
		$display("checks=%0d mismatches=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rdc(8'h09, 32'h0);
		rdc(8'h0C, 32'h0);
		apb(1'b1, 8'h0C, 32'hA5);
		rdc(8'h0C, 32'h0);
		apb(1'b0, 8'h0D, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 8'h0B, 32'hD8);
		rdc(8'h0B, 32'h90);
		$display("test reset done");
		// Event spacing, single and doubled period
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, 8'h0B, {24'h0, 8'h90 | 8'(d << 5)});
			wup(0, t1);
			rdc(8'h0B, {24'h0, 8'h98 | 8'(d << 5)});
			wup(0, t2);
			chk(32'(t2 - t1), 32'(250 * P * 10 * (d + 1)));
			rdc(8'h0B, {24'h0, 8'h98 | 8'(d << 5)});
			rdc(8'h0B, {24'h0, 8'h90 | 8'(d << 5)});
		end
		$display("test timebase one done");
		// Random reload, applied from the next overflow on
		v1 = 32'($random(seed) & 32'h7F);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h09, v1);
		rdc(8'h09, v1);
		rdc(8'h08, 32'h3);
		wup(1, t1);
		rdc(8'h08, 32'h3);
		wup(1, t2);
		chk(32'(t2 - t1), 32'((256 - v1) * P * 10));
		rdc(8'h08, 32'h3);
		rdc(8'h08, 32'h2);
		apb(1'b0, 8'h0A, 32'h0);
		chk({31'h0, rd >= v1 && rd <= 32'hFF}, 32'h1);
		$display("test timebase two done");
		// Halt freezes the counter
		halt_mode <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, 8'h0A, 32'h0);
		v1 = rd;
		repeat (20) @(posedge clk);
		rdc(8'h0A, v1);
		halt_mode <= 1'b0;
		$display("test halt done");
		// Capture, an edge while flagged, then a fresh capture
		dtct_pin_model_inst.flip(3);
		t1 = $time;
		wup(2, t2);
		dtct_pin_model_inst.flip(40);
		repeat (10) @(posedge clk);
		apb(1'b0, 8'h0C, 32'h0);
		v1 = rd;
		apb(1'b0, 8'h0B, 32'h0);
		chk(rd & 32'h40, 32'h0);
		dtct_pin_model_inst.flip(30);
		t2 = $time;
		// Both edges launched at the same clock phase, so latencies cancel
		de = int'((t2 - t1) / (10 * P)) % 250;
		wup(2, t2);
		apb(1'b0, 8'h0C, 32'h0);
		dv = (int'(rd) - int'(v1) + 250) % 250;
		chk({31'h0, dv >= de - 3 && dv <= de + 3}, 32'h1);
		$display("test capture done");
		final_report();
	end

	// Watchdog well beyond the expected run
	initial begin
		#400us;
		errors++;
		final_report();
	end
endmodule : dtct_test
